/* File: hdl/timer_pkg.sv */
package timer_pkg;

  // Sizes
  localparam int NUM_CH = 8;
  localparam int CW = 16;
  localparam int AW = 8;
  localparam int PSW = 7;

  // Register map, byte addresses
  localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
  localparam logic [AW-1:0] ADDR_COUNT = 8'h04;
  localparam logic [AW-1:0] ADDR_MODULO = 8'h08;
  localparam logic [AW-1:0] ADDR_CH_BASE = 8'h10;
  localparam int CH_STRIDE_SHIFT = 3;
  localparam int CH_VALUE_SEL_BIT = 2;

  // Module control field positions
  localparam int CTRL_CLK_LSB = 0;
  localparam int CTRL_PS_LSB = 2;
  localparam int CTRL_CENTER_BIT = 5;
  localparam int CTRL_OVF_BIT = 7;

  // Channel control field positions
  localparam int CH_ELS_LSB = 0;
  localparam int CH_MS_LSB = 2;
  localparam int CH_FLAG_BIT = 7;

  // Reset and special values
  localparam logic [CW-1:0] COUNT_ZERO = 16'h0000;
  localparam logic [CW-1:0] COUNT_ONE = 16'h0001;
  localparam logic [CW-1:0] COUNT_ALL_ONES = 16'hffff;
  localparam logic [CW-1:0] MODULO_RESET = 16'h0000;
  localparam logic [CW-1:0] VALUE_RESET = 16'h0000;
  localparam logic [PSW-1:0] PS_ALL_ONES = 7'h7f;
  localparam logic [2:0] PS_RESET = 3'h0;

  // Edge/level codes
  localparam logic [1:0] ELS_OFF = 2'b00;
  localparam logic [1:0] ELS_TOGGLE = 2'b01;
  localparam logic [1:0] ELS_CLEAR = 2'b10;
  localparam logic [1:0] ELS_SET = 2'b11;

  // Channel mode codes (upper bit set means edge PWM)
  localparam logic [1:0] MS_CAPTURE = 2'b00;
  localparam logic [1:0] MS_COMPARE = 2'b01;

  typedef enum logic [1:0] {
    CLK_OFF = 2'b00,
    CLK_BUS = 2'b01,
    CLK_FIXED = 2'b10,
    CLK_EXT = 2'b11
  } clk_src_t;

  typedef enum logic {
    DIR_UP = 1'b0,
    DIR_DOWN = 1'b1
  } count_dir_t;

endpackage

/* File: hdl/pin_edge_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_edge_sync
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Raw level
  input wire logic din,
  // Edge pulses
  output logic rise,
  output logic fall
);

  logic meta;
  logic stable;
  logic last;

  // Two-stage synchroniser plus one history stage; only stable feeds the edge test
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta <= 1'b0;
      stable <= 1'b0;
      last <= 1'b0;
    end
    else
    begin
      meta <= din;
      stable <= meta;
      last <= stable;
    end
  end

  // A level held across one clock edge is enough for a pulse to be seen
  assign rise = stable & ~last;
  assign fall = ~stable & last;

endmodule // pin_edge_sync
`default_nettype wire

/* File: hdl/timer_capture_compare_pwm.sv */
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module timer_capture_compare_pwm
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Register port
  input wire logic [timer_pkg::AW-1:0] reg_addr,
  input wire logic [timer_pkg::CW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [timer_pkg::CW-1:0] reg_rdata,
  // System state and clock sources
  input wire logic background_debug_mode,
  input wire logic fixed_clk_tick,
  input wire logic external_count_clock,
  // Channel pins
  input wire logic [timer_pkg::NUM_CH-1:0] channel_pin_in,
  output logic [timer_pkg::NUM_CH-1:0] channel_pin_out,
  output logic [timer_pkg::NUM_CH-1:0] channel_pin_oe,
  // General-purpose port controls for shared pins
  input wire logic [timer_pkg::NUM_CH-1:0] port_data,
  input wire logic [timer_pkg::NUM_CH-1:0] port_dir,
  // Status
  output logic overflow_flag,
  output logic [timer_pkg::NUM_CH-1:0] channel_flag
);

  // Channel register hit: 0 none, 1 control, 2 value
  function automatic logic [1:0] ch_hit(input logic [timer_pkg::AW-1:0] a, input int n);
    logic [timer_pkg::AW-1:0] rel;
    rel = a - timer_pkg::ADDR_CH_BASE;
    ch_hit = 2'b00;
    if (a >= timer_pkg::ADDR_CH_BASE && a[1:0] == 2'b00 &&
        int'(rel >> timer_pkg::CH_STRIDE_SHIFT) == n)
    begin
      ch_hit = rel[timer_pkg::CH_VALUE_SEL_BIT] ? 2'b10 : 2'b01;
    end
  endfunction

  // Module control state
  timer_pkg::clk_src_t clock_source_select;
  logic [2:0] prescale_sel;
  logic center_align_select;
  logic [timer_pkg::CW-1:0] modulo_value;
  logic [timer_pkg::CW-1:0] timer_count;
  timer_pkg::count_dir_t count_dir;
  logic [timer_pkg::PSW-1:0] prescale_cnt;
  logic count_moved;
  logic period_end;

  // Per-channel state
  logic [1:0] edge_level_select [timer_pkg::NUM_CH];
  logic [1:0] channel_mode_select [timer_pkg::NUM_CH];
  logic [timer_pkg::CW-1:0] channel_value [timer_pkg::NUM_CH];
  logic [timer_pkg::NUM_CH-1:0] out_level;

  // Decoded strobes
  logic wr_ctrl;
  logic wr_count;
  logic wr_modulo;
  assign wr_ctrl = reg_wr && reg_addr == timer_pkg::ADDR_CTRL;
  assign wr_count = reg_wr && reg_addr == timer_pkg::ADDR_COUNT;
  assign wr_modulo = reg_wr && reg_addr == timer_pkg::ADDR_MODULO;

  // External clock edge, synchronised to the bus clock
  logic ext_rise;
  pin_edge_sync u_ext_sync
  (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .din(external_count_clock),
    .rise(ext_rise),
    .fall()
  );

  // Prescaler input tick from the chosen source
  logic src_tick;
  always_comb
  begin
    unique case (clock_source_select)
      timer_pkg::CLK_OFF: src_tick = 1'b0;
      timer_pkg::CLK_BUS: src_tick = 1'b1;
      timer_pkg::CLK_FIXED: src_tick = fixed_clk_tick;
      timer_pkg::CLK_EXT: src_tick = ext_rise;
    endcase
  end

  // Divide-by 2^n tap; debug halt freezes the whole chain
  logic [timer_pkg::PSW-1:0] ps_mask;
  logic src_live;
  logic count_en;
  assign ps_mask = ~(timer_pkg::PS_ALL_ONES << prescale_sel);
  assign src_live = src_tick && !background_debug_mode;
  assign count_en = src_live && ((prescale_cnt & ps_mask) == ps_mask);

  // Module control register; no clock source leaves the timer idle after reset
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      clock_source_select <= timer_pkg::CLK_OFF;
      prescale_sel <= timer_pkg::PS_RESET;
      center_align_select <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      clock_source_select <= timer_pkg::clk_src_t'(reg_wdata[timer_pkg::CTRL_CLK_LSB +: 2]);
      prescale_sel <= reg_wdata[timer_pkg::CTRL_PS_LSB +: 3];
      center_align_select <= reg_wdata[timer_pkg::CTRL_CENTER_BIT];
    end
  end

  // Modulo register
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      modulo_value <= timer_pkg::MODULO_RESET;
    end
    else if (wr_modulo)
    begin
      modulo_value <= reg_wdata;
    end
  end

  // Prescaler; restarts with the counter so the first period is whole
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prescale_cnt <= '0;
    end
    else if (wr_count)
    begin
      prescale_cnt <= '0;
    end
    else if (src_live)
    begin
      prescale_cnt <= prescale_cnt + 1'b1;
    end
  end

  // Next counter value, direction and period end
  logic free_run;
  logic [timer_pkg::CW-1:0] next_count;
  timer_pkg::count_dir_t next_dir;
  logic next_wrap;
  assign free_run = modulo_value == timer_pkg::COUNT_ZERO ||
                    modulo_value == timer_pkg::COUNT_ALL_ONES;
  always_comb
  begin
    next_count = timer_count + timer_pkg::COUNT_ONE;
    next_dir = timer_pkg::DIR_UP;
    next_wrap = 1'b0;
    if (center_align_select && !free_run)
    begin
      unique case (count_dir)
        timer_pkg::DIR_UP:
        begin
          if (timer_count >= modulo_value)
          begin
            next_count = timer_count - timer_pkg::COUNT_ONE;
            next_dir = timer_pkg::DIR_DOWN;
          end
        end
        timer_pkg::DIR_DOWN:
        begin
          if (timer_count == timer_pkg::COUNT_ZERO)
          begin
            next_wrap = 1'b1;
          end
          else
          begin
            next_count = timer_count - timer_pkg::COUNT_ONE;
            next_dir = timer_pkg::DIR_DOWN;
          end
        end
      endcase
    end
    else if (!free_run && timer_count >= modulo_value)
    begin
      next_count = timer_pkg::COUNT_ZERO;
      next_wrap = 1'b1;
    end
    else if (timer_count == timer_pkg::COUNT_ALL_ONES)
    begin
      next_wrap = 1'b1;
    end
  end

  // Counter; a write zeroes it whatever the data, a read leaves it alone
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      timer_count <= timer_pkg::COUNT_ZERO;
      count_dir <= timer_pkg::DIR_UP;
    end
    else if (wr_count)
    begin
      timer_count <= timer_pkg::COUNT_ZERO;
      count_dir <= timer_pkg::DIR_UP;
    end
    else if (count_en)
    begin
      timer_count <= next_count;
      count_dir <= next_dir;
    end
  end

  // Marks a freshly reached count so each value matches only once
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      count_moved <= 1'b0;
      period_end <= 1'b0;
    end
    else
    begin
      count_moved <= (count_en || wr_count) && clock_source_select != timer_pkg::CLK_OFF;
      period_end <= count_en && !wr_count && next_wrap;
    end
  end

  // Overflow flag; a new period end beats a clear in the same cycle
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      overflow_flag <= 1'b0;
    end
    else if (period_end)
    begin
      overflow_flag <= 1'b1;
    end
    else if (wr_ctrl && reg_wdata[timer_pkg::CTRL_OVF_BIT])
    begin
      overflow_flag <= 1'b0;
    end
  end

  // Channels
  genvar gi;
  generate
    for (gi = 0; gi < timer_pkg::NUM_CH; gi++)
    begin : g_ch
      logic pin_rise;
      logic pin_fall;
      logic func_on;
      logic is_cap;
      logic is_cmp;
      logic is_edge_aligned_pwm;
      logic drive;
      logic cap_evt;
      logic match;
      logic wr_cctrl;
      logic wr_cval;

      pin_edge_sync u_pin_sync
      (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .din(channel_pin_in[gi]),
        .rise(pin_rise),
        .fall(pin_fall)
      );

      // Mode decode; center-align overrides every per-channel mode
      assign func_on = edge_level_select[gi] != timer_pkg::ELS_OFF &&
                       clock_source_select != timer_pkg::CLK_OFF;
      assign is_cap = !center_align_select && channel_mode_select[gi] == timer_pkg::MS_CAPTURE;
      assign is_cmp = !center_align_select && channel_mode_select[gi] == timer_pkg::MS_COMPARE;
      assign is_edge_aligned_pwm = !center_align_select && channel_mode_select[gi][1];
      assign drive = func_on && !is_cap;
      assign cap_evt = func_on && is_cap &&
                       ((edge_level_select[gi][0] && pin_rise) ||
                        (edge_level_select[gi][1] && pin_fall));
      assign match = count_moved && timer_count == channel_value[gi] && !is_cap;
      assign wr_cctrl = reg_wr && ch_hit(reg_addr, gi) == 2'b01;
      assign wr_cval = reg_wr && ch_hit(reg_addr, gi) == 2'b10;

      // Channel control register
      always_ff @(posedge sys_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          edge_level_select[gi] <= timer_pkg::ELS_OFF;
          channel_mode_select[gi] <= timer_pkg::MS_CAPTURE;
        end
        else if (wr_cctrl)
        begin
          edge_level_select[gi] <= reg_wdata[timer_pkg::CH_ELS_LSB +: 2];
          channel_mode_select[gi] <= reg_wdata[timer_pkg::CH_MS_LSB +: 2];
        end
      end

      // Channel value; a capture wins over a software write in the same cycle
      always_ff @(posedge sys_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          channel_value[gi] <= timer_pkg::VALUE_RESET;
        end
        else if (cap_evt)
        begin
          channel_value[gi] <= timer_count;
        end
        else if (wr_cval)
        begin
          channel_value[gi] <= reg_wdata;
        end
      end

      // Channel flag; compare with no pin action still flags, as a software timer
      always_ff @(posedge sys_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          channel_flag[gi] <= 1'b0;
        end
        else if (cap_evt || (match && clock_source_select != timer_pkg::CLK_OFF))
        begin
          channel_flag[gi] <= 1'b1;
        end
        else if (wr_cctrl && reg_wdata[timer_pkg::CH_FLAG_BIT])
        begin
          channel_flag[gi] <= 1'b0;
        end
      end

      // Output level; tracks the pin while idle so compare starts from it
      always_ff @(posedge sys_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          out_level[gi] <= 1'b0;
        end
        else if (!drive)
        begin
          out_level[gi] <= channel_pin_in[gi];
        end
        else if (center_align_select)
        begin
          if (match && count_dir == timer_pkg::DIR_DOWN)
          begin
            out_level[gi] <= !edge_level_select[gi][0];
          end
          else if (match)
          begin
            out_level[gi] <= edge_level_select[gi][0];
          end
        end
        else if (is_edge_aligned_pwm)
        begin
          if (match)
          begin
            out_level[gi] <= edge_level_select[gi][0];
          end
          else if (count_moved && timer_count == timer_pkg::COUNT_ZERO)
          begin
            out_level[gi] <= !edge_level_select[gi][0];
          end
        end
        else if (is_cmp && match)
        begin
          unique case (edge_level_select[gi])
            timer_pkg::ELS_TOGGLE: out_level[gi] <= !out_level[gi];
            timer_pkg::ELS_CLEAR: out_level[gi] <= 1'b0;
            timer_pkg::ELS_SET: out_level[gi] <= 1'b1;
            timer_pkg::ELS_OFF: out_level[gi] <= out_level[gi];
          endcase
        end
      end

      // Pin ownership: driven, forced input, or handed back to the port
      assign channel_pin_out[gi] = drive ? out_level[gi] : port_data[gi];
      assign channel_pin_oe[gi] = drive ? 1'b1 : (func_on ? 1'b0 : port_dir[gi]);
    end
  endgenerate

  // Read mux; unmapped addresses answer zero
  logic [timer_pkg::CW-1:0] next_rdata;
  always_comb
  begin
    next_rdata = '0;
    if (reg_addr == timer_pkg::ADDR_CTRL)
    begin
      next_rdata[timer_pkg::CTRL_CLK_LSB +: 2] = clock_source_select;
      next_rdata[timer_pkg::CTRL_PS_LSB +: 3] = prescale_sel;
      next_rdata[timer_pkg::CTRL_CENTER_BIT] = center_align_select;
      next_rdata[timer_pkg::CTRL_OVF_BIT] = overflow_flag;
    end
    else if (reg_addr == timer_pkg::ADDR_COUNT)
    begin
      next_rdata = timer_count;
    end
    else if (reg_addr == timer_pkg::ADDR_MODULO)
    begin
      next_rdata = modulo_value;
    end
    for (int n = 0; n < timer_pkg::NUM_CH; n++)
    begin
      if (ch_hit(reg_addr, n) == 2'b01)
      begin
        next_rdata[timer_pkg::CH_ELS_LSB +: 2] = edge_level_select[n];
        next_rdata[timer_pkg::CH_MS_LSB +: 2] = channel_mode_select[n];
        next_rdata[timer_pkg::CH_FLAG_BIT] = channel_flag[n];
      end
      else if (ch_hit(reg_addr, n) == 2'b10)
      begin
        next_rdata = channel_value[n];
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      reg_rdata <= '0;
    end
    else
    begin
      reg_rdata <= reg_rd ? next_rdata : '0;
    end
  end

endmodule // timer_capture_compare_pwm
`default_nettype wire

/* File: tb/timer_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module timer_checker
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Pins and status
  input wire logic background_debug_mode,
  input wire logic [7:0] channel_pin_out,
  input wire logic [7:0] channel_pin_oe,
  input wire logic [7:0] port_data,
  input wire logic [7:0] port_dir,
  input wire logic overflow_flag,
  input wire logic [7:0] channel_flag
);
  logic [1:0] src;
  logic [7:0] ch_off;
  logic [3:0] idx;
  logic wr_ch, cnt_rd, cnt_wr;

  // Decodes of the register strobes
  assign idx = reg_addr[6:3] - 4'h2;
  assign wr_ch = reg_wr && reg_addr >= 8'h10 && reg_addr < 8'h50 && reg_addr[2:0] == 3'h0;
  assign cnt_rd = reg_rd && reg_addr == timer_pkg::ADDR_COUNT;
  assign cnt_wr = reg_wr && reg_addr == timer_pkg::ADDR_COUNT;

  // Shadow of clock source and idle channels, so pin ownership is known from outside
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      src <= 2'h0;
      ch_off <= 8'hff;
    end
    else
    begin
      if (reg_wr && reg_addr == timer_pkg::ADDR_CTRL)
        src <= reg_wdata[1:0];
      if (wr_ch)
        ch_off[idx[2:0]] <= (reg_wdata[1:0] == 2'h0);
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_clear_read;
    cnt_wr ##2 cnt_rd;
  endsequence
  sequence s_frozen_reads;
    background_debug_mode ##1 (background_debug_mode && cnt_rd) [*2];
  endsequence

  property p_reset_pins;
    $rose(rstn) |-> channel_pin_oe == port_dir && channel_pin_out == port_data;
  endproperty
  property p_src_off_pins;
    src == 2'h0 |-> channel_pin_oe == port_dir && channel_pin_out == port_data;
  endproperty
  property p_ch_off_pins;
    (ch_off & ((channel_pin_oe ^ port_dir) | (channel_pin_out ^ port_data))) == 8'h00;
  endproperty
  property p_count_clear;
    s_clear_read |=> reg_rdata <= 16'h0002;
  endproperty
  property p_debug_freeze;
    s_frozen_reads |=> reg_rdata == $past(reg_rdata);
  endproperty
  property p_ch_flag_hold;
    (($past(channel_flag) & ~channel_flag) != 8'h00) |-> $past(wr_ch);
  endproperty
  property p_ovf_hold;
    $fell(overflow_flag) |-> $past(reg_wr && reg_addr == timer_pkg::ADDR_CTRL);
  endproperty
  property p_rdata_idle;
    !reg_rd |=> reg_rdata == 16'h0000;
  endproperty

  a_reset_pins: assert property (p_reset_pins) else $error("pins not under port control after reset");
  a_src_off_pins: assert property (p_src_off_pins) else $error("pins driven with timer off");
  a_ch_off_pins: assert property (p_ch_off_pins) else $error("idle channel kept its pin");
  a_count_clear: assert property (p_count_clear) else $error("count not cleared by write");
  a_debug_freeze: assert property (p_debug_freeze) else $error("count moved in debug halt");
  a_ch_flag_hold: assert property (p_ch_flag_hold) else $error("channel flag dropped alone");
  a_ovf_hold: assert property (p_ovf_hold) else $error("period flag dropped alone");
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
endmodule // timer_checker

bind timer_capture_compare_pwm timer_checker u_chk
(
  .sys_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .background_debug_mode,
  .channel_pin_out, .channel_pin_oe, .port_data, .port_dir, .overflow_flag, .channel_flag
);
`default_nettype wire

/* File: tb/pin_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_partner
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Requests from the bench
  input wire logic [7:0] pin_req,
  input wire logic ext_run,
  // Lines toward the timer
  output logic [7:0] pin_level,
  output logic ext_clk
);
  logic [1:0] div;
  logic [2:0] held;

  // Count clock at a quarter of the bus rate, standing low between bursts
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      div <= 2'h0;
      ext_clk <= 1'b0;
    end
    else
    begin
      div <= ext_run ? div + 2'h1 : 2'h0;
      ext_clk <= ext_run && div[1];
    end
  end

  // New level only once the old one stood four cycles, so no pulse is too short to see
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_level <= 8'h00;
      held <= 3'h0;
    end
    else if (pin_req != pin_level && held >= 3'h3)
    begin
      pin_level <= pin_req;
      held <= 3'h0;
    end
    else if (held != 3'h7)
      held <= held + 3'h1;
  end
endmodule // pin_partner
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk, rstn, reg_wr, reg_rd, background_debug_mode, fixed_clk_tick, external_count_clock;
  logic overflow_flag, ext_run;
  logic rd_d = 1'b0;
  logic [7:0] reg_addr, channel_pin_in, channel_pin_out, channel_pin_oe, port_data, port_dir;
  logic [7:0] channel_flag, pin_req, pin_level, prev;
  logic [15:0] reg_wdata, reg_rdata;
  logic [31:0] exp_q[$];
  logic [15:0] cmp_cfg[4] = '{16'h0085, 16'h0086, 16'h0087, 16'h0084};
  logic [7:0] idle_addr[6] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h48, 8'hf0};
  int num_errors, checks_done, seed, hi0, hi1, rises, al, i;

  timer_capture_compare_pwm DUT
  (
    .sys_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .background_debug_mode,
    .fixed_clk_tick, .external_count_clock, .channel_pin_in, .channel_pin_out, .channel_pin_oe,
    .port_data, .port_dir, .overflow_flag, .channel_flag
  );
  pin_partner far_side
  (
    .sys_clk, .rstn, .pin_req, .ext_run, .pin_level, .ext_clk(external_count_clock)
  );

  // Pad level: whoever enables wins, the far side otherwise
  assign channel_pin_in = (channel_pin_oe & channel_pin_out) | (~channel_pin_oe & pin_level);

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Reads n times back to back; expectations are noted with a mask of bits that matter
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m, input int n);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    repeat (n)
    begin
      exp_q.push_back({m, e});
      @(posedge sys_clk);
    end
    reg_rd <= 1'b0;
  endtask

  // High time per channel, rising edges of c0 and how many of them meet a fall of c1
  task automatic measure(input int n, input int c0, input int c1);
    hi0 = 0;
    hi1 = 0;
    rises = 0;
    al = 0;
    @(negedge sys_clk);
    prev = channel_pin_out;
    repeat (n)
    begin
      @(negedge sys_clk);
      hi0 += int'(channel_pin_out[c0]);
      hi1 += int'(channel_pin_out[c1]);
      if (channel_pin_out[c0] && !prev[c0])
      begin
        rises++;
        al += int'(!channel_pin_out[c1] && prev[c1]);
      end
      prev = channel_pin_out;
    end
  endtask

  task automatic finish_test;
    $display("Checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Read data stands one cycle after the strobe; the oldest note is compared there
  always @(posedge sys_clk)
  begin
    if (rd_d)
    begin
      chk(reg_rdata & exp_q[0][31:16], exp_q[0][15:0]);
      void'(exp_q.pop_front());
    end
    rd_d <= reg_rd;
  end

  // Whole run is under a thousand cycles; this cuts a hang short
  initial
  begin
    #100000;
    num_errors++;
    finish_test;
  end

  initial
  begin
    seed = 32'h148775c8;
    {rstn, reg_wr, reg_rd, background_debug_mode, fixed_clk_tick, ext_run} = 6'h00;
    {reg_addr, reg_wdata, pin_req} = 32'h0;
    port_data = 8'($random(seed));
    port_dir = 8'($random(seed));
    tick(8);
    rstn <= 1'b1;
    @(negedge sys_clk);
    chk({channel_pin_oe, channel_pin_out}, {port_dir, port_data});
    foreach (idle_addr[k]) rd(idle_addr[k], 16'h0000, 16'hffff, 1);
    // Edge PWM: high-true duty 5 and low-true duty 3 over modulo 8
    wr(8'h08, 16'h0008);
    wr(8'h14, 16'h0005);
    wr(8'h1c, 16'h0003);
    wr(8'h10, 16'h000a);
    wr(8'h18, 16'h000b);
    wr(8'h00, 16'h0001);
    tick(20);
    measure(18, 0, 1);
    chk(16'(hi0), 16'h000a);
    chk(16'(hi1), 16'h000c);
    chk(16'({8'(rises), 8'(al)}), 16'h0202);
    chk(16'({overflow_flag, channel_flag[1:0], channel_pin_oe[1:0]}), 16'h001f);
    wr(8'h00, 16'h0081);
    // Center mode takes over channel 1 even though it is set for capture
    wr(8'h1c, 16'h0002);
    wr(8'h18, 16'h0002);
    wr(8'h00, 16'h0021);
    tick(20);
    measure(32, 0, 1);
    chk(16'(hi0), 16'h0014);
    chk(16'(hi1), 16'h0008);
    // Compare on four channels, one for each pin action, free-running count
    @(posedge sys_clk);
    port_data <= 8'h0c;
    port_dir <= 8'hff;
    wr(8'h00, 16'h0000);
    wr(8'h08, 16'h0000);
    for (i = 2; i < 6; i++)
    begin
      wr(8'(8'h14 + 8 * i), 16'h0020);
      wr(8'(8'h10 + 8 * i), cmp_cfg[i - 2]);
    end
    wr(8'h04, 16'h0000);
    wr(8'h00, 16'h0001);
    tick(10);
    @(negedge sys_clk);
    chk(16'({channel_pin_out[2], channel_flag[5:2]}), 16'h0010);
    tick(40);
    @(negedge sys_clk);
    chk(16'(channel_pin_out[5:2]), 16'h0004);
    chk(16'(channel_flag[5:2]), 16'h000f);
    rd(8'h04, 16'h0020, 16'hffe0, 1);
    // Capture: rising on 6, falling on 7, none on 1
    @(posedge sys_clk);
    port_dir <= 8'h00;
    wr(8'h00, 16'h0000);
    wr(8'h18, 16'h0080);
    wr(8'h40, 16'h0081);
    wr(8'h48, 16'h0082);
    wr(8'h04, 16'h0000);
    wr(8'h00, 16'h0001);
    tick(36);
    pin_req <= 8'hc2;
    tick(12);
    @(negedge sys_clk);
    chk(16'(channel_flag & 8'hc2), 16'h0040);
    rd(8'h44, 16'h0020, 16'hfff0, 1);
    pin_req <= 8'h00;
    tick(12);
    @(negedge sys_clk);
    chk(16'(channel_flag & 8'hc2), 16'h00c0);
    // External count clock at a quarter rate
    wr(8'h00, 16'h0000);
    ext_run <= 1'b1;
    wr(8'h04, 16'h0000);
    wr(8'h00, 16'h0003);
    tick(80);
    rd(8'h04, 16'h0010, 16'hfff0, 1);
    ext_run <= 1'b0;
    fixed_clk_tick <= 1'b1;
    // Fixed tick source halved by the prescaler; counter write with random data, then a debug halt
    wr(8'h00, 16'h0006);
    wr(8'h04, 16'($random(seed)));
    rd(8'h04, 16'h0000, 16'hfffc, 1);
    background_debug_mode <= 1'b1;
    wr(8'h04, 16'h0000);
    tick(20);
    rd(8'h04, 16'h0000, 16'hffff, 2);
    background_debug_mode <= 1'b0;
    tick(20);
    rd(8'h04, 16'h0008, 16'hfff8, 1);
    tick(3);
    finish_test;
  end
endmodule // tb_top
`default_nettype wire
